// ---- logic/gpp78_pkg.sv ----
// Package with register map, reset values, modes and carrier types of the port 7/8 block
package gpp78_pkg;

  // ***********************
  // Bus and register map
  // ***********************
  localparam int          GPP78_ADR_W     = 18;
  localparam int          GPP78_DAT_W     = 32;
  localparam logic [15:0] IDX_A_LATCH     = 16'hffda;
  localparam logic [15:0] IDX_B_LATCH     = 16'hffdb;
  localparam logic [15:0] IDX_A_DIR       = 16'hffea;
  localparam logic [15:0] IDX_B_DIR       = 16'hffeb;

  // ***********************
  // Reset and read values
  // ***********************
  localparam logic [7:0]  RST_LATCH       = 8'h00;
  localparam logic [7:0]  RST_DIR         = 8'h00;
  localparam logic [7:0]  DIR_READ_VALUE  = 8'hff;
  localparam logic [7:0]  PORT_A_USED     = 8'hf8;
  localparam logic [31:0] UNMAPPED_READ   = 32'h0000_0000;

  // ***********************
  // Pin positions
  // ***********************
  localparam int          A_CMP_BIT       = 6;
  localparam int          A_TCLK_BIT      = 5;
  localparam int          A_TRST_BIT      = 4;
  localparam logic [3:0]  OSEL_PLAIN_PORT = 4'h0;

  // ***********************
  // Operating modes
  // ***********************
  typedef enum logic [5:0] {
    GPP78_ACTIVE    = 6'h01,
    GPP78_SUBACTIVE = 6'h02,
    GPP78_SLEEP     = 6'h04,
    GPP78_SUBSLEEP  = 6'h08,
    GPP78_WATCH     = 6'h10,
    GPP78_STANDBY   = 6'h20
  } gpp78_pmode_t;

  // ***********************
  // Carriers
  // ***********************
  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [3:0]             sel;
    logic [GPP78_ADR_W-1:0] adr;
    logic [GPP78_DAT_W-1:0] dat;
  } gpp78_wb_req_t;

  typedef struct packed {
    logic [7:0] o;
    logic [7:0] oe;
  } gpp78_pins_t;

endpackage

// ---- logic/gpp78_ports.sv ----
// Two byte-wide general-purpose I/O ports with a classic Wishbone register slave
//
// Notes on behaviour
// - A five-pin-port pin is an input at direction 0 and an output at 1; pins 5 and 4 always feed the timer.
// - Pin 6 carries the timer compare output while the select field is nonzero, else its direction bit rules.
// - Five-pin-port pins float in reset and standby, hold in sleep, subsleep and watch, and run in both active modes.
// - The eight-pin port has eight independent two-way pins 7 to 0, each on its own bit of data and direction.
// - An eight-pin-port pin whose direction bit is 1 is driven from its latch bit.
// - An eight-pin-port pin whose direction bit is 0 is left undriven and read as an input.
// - Reading the eight-pin data register gives the latch bit where direction is 1.
// - Reading the eight-pin data register gives the sampled pin where direction is 0.
// - The eight-pin latch is an eight-bit read-write register holding all output values.
// - Reset clears the eight-pin latch to zero.
// - Reset clears the eight-pin direction register to zero so all pins start as inputs.
// - The eight-pin direction register is write-only and reads as all ones.
// - Reading the five-pin data register gives latch bits where direction is 1 and pin levels where it is 0.
// - Bits 2 to 0 of the five-pin data register read as zero and ignore writes.
// - The five-pin direction register is write-only, resets to zero and reads as all ones.
`timescale 1ns/1ps

module gpp78_ports (
  input  wire logic                    clock,
  input  wire logic                    rst,
  input  wire gpp78_pkg::gpp78_wb_req_t wb_req,
  output logic [gpp78_pkg::GPP78_DAT_W-1:0] wb_dat_o,
  output logic                         wb_ack_o,
  input  wire gpp78_pkg::gpp78_pmode_t power_mode,
  input  wire logic [7:0]              port_a_in,
  output gpp78_pkg::gpp78_pins_t       port_a_pins,
  input  wire logic [7:0]              port_b_in,
  output gpp78_pkg::gpp78_pins_t       port_b_pins,
  input  wire logic [3:0]              timer_output_select,
  input  wire logic                    timer_compare_out,
  output logic                         timer_clock_in,
  output logic                         timer_reset_in
);
  import gpp78_pkg::*;

  // ***********************
  // Declarations
  // ***********************
  logic [7:0]  a_latch_q;
  logic [7:0]  a_dir_q;
  logic [7:0]  b_latch_q;
  logic [7:0]  b_dir_q;
  logic [7:0]  a_meta_q;
  logic [7:0]  a_sync_q;
  logic [7:0]  b_meta_q;
  logic [7:0]  b_sync_q;
  logic [7:0]  a_out_q;
  logic [7:0]  a_oe_q;
  logic [7:0]  b_out_q;
  logic [7:0]  b_oe_q;
  logic [7:0]  a_out_d;
  logic [7:0]  a_oe_d;
  logic [7:0]  b_read;
  logic [7:0]  a_read;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [15:0] req_idx;
  logic        req_new;
  logic        wr_done;
  logic        hit_a_latch;
  logic        hit_a_dir;
  logic        hit_b_latch;
  logic        hit_b_dir;
  logic        a_freeze;
  logic        a_float;
  logic        timer_clk_q;
  logic        timer_rst_q;

  // ***********************
  // Bus decode
  // ***********************
  // Register offsets are word indices, so the byte address is four times the index
  assign req_idx     = wb_req.adr[GPP78_ADR_W-1:2];
  assign req_new     = wb_req.cyc && wb_req.stb && !ack_q;
  assign wr_done     = wb_req.cyc && wb_req.stb && wb_req.we && wb_req.sel[0] && ack_q;
  assign hit_a_latch = (req_idx == IDX_A_LATCH);
  assign hit_a_dir   = (req_idx == IDX_A_DIR);
  assign hit_b_latch = (req_idx == IDX_B_LATCH);
  assign hit_b_dir   = (req_idx == IDX_B_DIR);

  // One wait state: ack rises the cycle after the request and falls the cycle after that
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_new;
    end
  end

  // ***********************
  // Input synchronisers
  // ***********************
  always_ff @(posedge clock) begin
    if (rst) begin
      a_meta_q <= 8'h00;
      a_sync_q <= 8'h00;
      b_meta_q <= 8'h00;
      b_sync_q <= 8'h00;
    end else begin
      a_meta_q <= port_a_in;
      a_sync_q <= a_meta_q;
      b_meta_q <= port_b_in;
      b_sync_q <= b_meta_q;
    end
  end

  // ***********************
  // Registers
  // ***********************
  always_ff @(posedge clock) begin
    if (rst) begin
      b_latch_q <= RST_LATCH;
    end else if (wr_done && hit_b_latch) begin
      b_latch_q <= wb_req.dat[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      b_dir_q <= RST_DIR;
    end else if (wr_done && hit_b_dir) begin
      b_dir_q <= wb_req.dat[7:0];
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      a_latch_q <= RST_LATCH;
    end else if (wr_done && hit_a_latch) begin
      a_latch_q <= wb_req.dat[7:0] & PORT_A_USED;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      a_dir_q <= RST_DIR;
    end else if (wr_done && hit_a_dir) begin
      a_dir_q <= wb_req.dat[7:0] & PORT_A_USED;
    end
  end

  // ***********************
  // Read path
  // ***********************
  // Output bits read the latch, input bits read the synchronised pin
  assign b_read = (b_dir_q & b_latch_q) | (~b_dir_q & b_sync_q);
  assign a_read = ((a_dir_q & a_latch_q) | (~a_dir_q & a_sync_q)) & PORT_A_USED;

  always_comb begin
    rdata_d = UNMAPPED_READ;
    if (hit_b_latch) begin
      rdata_d = {24'h00_0000, b_read};
    end else if (hit_b_dir) begin
      rdata_d = {24'h00_0000, DIR_READ_VALUE};
    end else if (hit_a_latch) begin
      rdata_d = {24'h00_0000, a_read};
    end else if (hit_a_dir) begin
      rdata_d = {24'h00_0000, DIR_READ_VALUE};
    end
  end

  // Read data is captured with the request so it stands steady under ack
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata_q <= UNMAPPED_READ;
    end else if (req_new) begin
      rdata_q <= rdata_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ***********************
  // Eight-pin port drivers
  // ***********************
  // Registered drivers add one cycle after a write but keep the pads glitch free
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_b_pin
      always_ff @(posedge clock) begin
        if (rst) begin
          b_oe_q[gi]  <= 1'b0;
          b_out_q[gi] <= 1'b0;
        end else begin
          b_oe_q[gi]  <= b_dir_q[gi];
          b_out_q[gi] <= b_latch_q[gi];
        end
      end
    end
  endgenerate

  assign port_b_pins.o  = b_out_q;
  assign port_b_pins.oe = b_oe_q;

  // ***********************
  // Five-pin port drivers
  // ***********************
  always_comb begin
    a_out_d = a_latch_q;
    a_oe_d  = a_dir_q;
    if (timer_output_select != OSEL_PLAIN_PORT) begin
      a_out_d[A_CMP_BIT] = timer_compare_out;
      a_oe_d[A_CMP_BIT]  = 1'b1;
    end
  end

  always_comb begin
    a_freeze = 1'b0;
    a_float  = 1'b0;
    case (power_mode)
      GPP78_ACTIVE: begin
        a_freeze = 1'b0;
      end
      GPP78_SUBACTIVE: begin
        a_freeze = 1'b0;
      end
      GPP78_SLEEP: begin
        a_freeze = 1'b1;
      end
      GPP78_SUBSLEEP: begin
        a_freeze = 1'b1;
      end
      GPP78_WATCH: begin
        a_freeze = 1'b1;
      end
      GPP78_STANDBY: begin
        a_float = 1'b1;
      end
      default: begin
        a_float = 1'b1;
      end
    endcase
  end

  // Frozen modes keep the last driven level; the latch itself may still change
  always_ff @(posedge clock) begin
    if (rst) begin
      a_oe_q  <= 8'h00;
      a_out_q <= 8'h00;
    end else if (a_float) begin
      a_oe_q  <= 8'h00;
      a_out_q <= a_out_q;
    end else if (!a_freeze) begin
      a_oe_q  <= a_oe_d & PORT_A_USED;
      a_out_q <= a_out_d & PORT_A_USED;
    end
  end

  assign port_a_pins.o  = a_out_q;
  assign port_a_pins.oe = a_oe_q;

  // ***********************
  // Timer inputs
  // ***********************
  // Pins 5 and 4 reach the timer in either direction, through the synchroniser
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_clk_q <= 1'b0;
      timer_rst_q <= 1'b0;
    end else begin
      timer_clk_q <= a_sync_q[A_TCLK_BIT];
      timer_rst_q <= a_sync_q[A_TRST_BIT];
    end
  end

  assign timer_clock_in = timer_clk_q;
  assign timer_reset_in = timer_rst_q;

  // ***********************
  // Elaboration checks
  // ***********************
  // Read data is built as three zero bytes over one register byte
  if (GPP78_DAT_W != 32) begin : g_chk_dat_w
    $error("gpp78_ports needs a 32-bit data bus");
  end
  // The word index compared against the map is sixteen bits wide
  if (GPP78_ADR_W != 18) begin : g_chk_adr_w
    $error("gpp78_ports needs an 18-bit byte address");
  end
  // Timer pins must sit among the usable five-pin-port bits
  if (PORT_A_USED[A_CMP_BIT] != 1'b1) begin : g_chk_cmp_bit
    $error("gpp78_ports compare pin outside the usable bits");
  end
  if (PORT_A_USED[A_TCLK_BIT] != 1'b1) begin : g_chk_tclk_bit
    $error("gpp78_ports timer clock pin outside the usable bits");
  end
  if (PORT_A_USED[A_TRST_BIT] != 1'b1) begin : g_chk_trst_bit
    $error("gpp78_ports timer reset pin outside the usable bits");
  end
  // Each timer function needs a pin of its own
  if ((A_CMP_BIT == A_TCLK_BIT) || (A_CMP_BIT == A_TRST_BIT) ||
      (A_TCLK_BIT == A_TRST_BIT)) begin : g_chk_pins_apart
    $error("gpp78_ports timer functions share a pin");
  end
  // Four registers need four distinct indices
  if ((IDX_A_LATCH == IDX_B_LATCH) || (IDX_A_DIR == IDX_B_DIR) ||
      (IDX_A_LATCH == IDX_A_DIR) || (IDX_B_LATCH == IDX_B_DIR)) begin : g_chk_map
    $error("gpp78_ports register indices overlap");
  end

endmodule // gpp78_ports

// ---- dv/gpp78_chk.sv ----
// Checker of bus answers and pin behaviour for the port 7/8 block
`timescale 1ns/1ps
module gpp78_chk (
  input logic                     clock,
  input logic                     rst,
  input gpp78_pkg::gpp78_wb_req_t wb_req,
  input logic [31:0]              wb_dat_o,
  input logic                     wb_ack_o,
  input gpp78_pkg::gpp78_pmode_t  power_mode,
  input logic [7:0]               port_a_in,
  input gpp78_pkg::gpp78_pins_t   port_a_pins,
  input gpp78_pkg::gpp78_pins_t   port_b_pins,
  input logic [3:0]               timer_output_select,
  input logic                     timer_compare_out,
  input logic                     timer_clock_in
);
  import gpp78_pkg::*;
  // ****************
  // Bus and pin checks
  // ****************
  logic rst_q;
  // The design still resets on the edge that releases rst, so checks wait one edge more
  always_ff @(posedge clock) begin
    rst_q <= rst;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst || rst_q);
  // Taken only while ack is low, so a held strobe is not counted twice
  wire tk = wb_req.cyc & wb_req.stb & ~wb_ack_o;
  wire rd = tk & ~wb_req.we;
  property p_ack; tk |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack not one pulse");
  property p_bdir; rd && wb_req.adr == {IDX_B_DIR, 2'b00} |=> wb_dat_o[7:0] == DIR_READ_VALUE; endproperty
  a_bdir: assert property (p_bdir) else $error("b dir read");
  property p_adir; rd && wb_req.adr == {IDX_A_DIR, 2'b00} |=> wb_dat_o[7:0] == DIR_READ_VALUE; endproperty
  a_adir: assert property (p_adir) else $error("a dir read");
  property p_resv; rd && wb_req.adr == {IDX_A_LATCH, 2'b00} |=> wb_dat_o[2:0] == 3'h0; endproperty
  a_resv: assert property (p_resv) else $error("a low bits");
  property p_rst; $fell(rst) |-> port_a_pins == 16'h0000 && port_b_pins == 16'h0000; endproperty
  a_rst: assert property (p_rst) else $error("pins after reset");
  property p_stby; power_mode == GPP78_STANDBY |=> port_a_pins.oe == 8'h00; endproperty
  a_stby: assert property (p_stby) else $error("standby drive");
  property p_frz; power_mode == GPP78_SLEEP |=> $stable(port_a_pins); endproperty
  a_frz: assert property (p_frz) else $error("sleep hold");
  property p_cmp;
    power_mode == GPP78_ACTIVE && timer_output_select != 4'h0 |=>
      port_a_pins.oe[6] && port_a_pins.o[6] == $past(timer_compare_out);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare pin");
  // Three flops from pad to timer input, so the pad must rest four samples
  property p_tclk; $stable(port_a_in[5]) [*4] |-> timer_clock_in == port_a_in[5]; endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock in");
endmodule // gpp78_chk

// ---- dv/gpp78_board.sv ----
// Board model: pads follow the chip where it drives, else the board level
`timescale 1ns/1ps
module gpp78_board (
  input gpp78_pkg::gpp78_pins_t port_a_pins,
  input gpp78_pkg::gpp78_pins_t port_b_pins,
  input logic [7:0]             a_ext,
  input logic [7:0]             b_ext,
  output logic [7:0]            port_a_in,
  output logic [7:0]            port_b_in
);
  import gpp78_pkg::*;
  assign port_a_in = (port_a_pins.oe & port_a_pins.o) | (~port_a_pins.oe & a_ext);
  assign port_b_in = (port_b_pins.oe & port_b_pins.o) | (~port_b_pins.oe & b_ext);
endmodule // gpp78_board

// ---- dv/tb_top.sv ----
// Self-checking bench for the port 7/8 block
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_top;
  import gpp78_pkg::*;
  localparam logic [17:0] AL = {IDX_A_LATCH, 2'b00};
  localparam logic [17:0] BL = {IDX_B_LATCH, 2'b00};
  localparam logic [17:0] AD = {IDX_A_DIR, 2'b00};
  localparam logic [17:0] BD = {IDX_B_DIR, 2'b00};
  logic          clock, rst, wb_ack_o, tco, tclk, trst;
  logic [31:0]   wb_dat_o;
  logic [7:0]    port_a_in, port_b_in, a_ext, b_ext, r;
  logic [3:0]    osel;
  gpp78_wb_req_t wb_req;
  gpp78_pmode_t  power_mode;
  gpp78_pins_t   port_a_pins, port_b_pins;
  int            num_errors = 0;
  int            total_checks = 0;
  // Rows: direction, latch, board level, expected read
  logic [7:0]    rows [4][4] = '{'{8'h00, 8'hff, 8'h5a, 8'h5a}, '{8'hff, 8'ha5, 8'h5a, 8'ha5},
                                 '{8'hf0, 8'ha5, 8'h3c, 8'hac}, '{8'h0f, 8'h5a, 8'hc3, 8'hca}};
  gpp78_ports dut (.clock, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .power_mode, .port_a_in, .port_a_pins,
    .port_b_in, .port_b_pins, .timer_output_select(osel), .timer_compare_out(tco), .timer_clock_in(tclk),
    .timer_reset_in(trst));
  gpp78_board brd (.port_a_pins, .port_b_pins, .a_ext, .b_ext, .port_a_in, .port_b_in);
  // ****************
  // Tasks
  // ****************
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  // One classic cycle; data is taken at the edge that sees ack, only the watchdog ends a wait
  task automatic wb(input logic w, input logic [17:0] a, input logic [7:0] d);
    wb_req <= '{1'b1, 1'b1, w, 4'hf, a, {24'h0, d}};
    do begin
      @(posedge clock);
    end while (wb_ack_o !== 1'b1);
    r = wb_dat_o[7:0];
    wb_req <= '0;
    @(posedge clock);
  endtask
  task stop_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************
  // Sequence
  // ****************
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  initial begin
    step(3000);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end
  initial begin
    rst = 1'b1;
    wb_req = '0;
    power_mode = GPP78_ACTIVE;
    a_ext = 8'h30;
    b_ext = 8'h00;
    osel = 4'h0;
    tco = 1'b0;
    step(12);
    rst <= 1'b0;
    step(1);
    for (int i = 0; i < 4; i++) begin
      b_ext <= rows[i][2];
      wb(1'b1, BL, rows[i][1]);
      wb(1'b1, BD, rows[i][0]);
      wb(1'b0, BD, 8'h00);
      `CHK(r, DIR_READ_VALUE)
      wb(1'b0, BL, 8'h00);
      `CHK(r, rows[i][3])
      `CHK(port_b_pins.oe, rows[i][0])
      `CHK(port_b_pins.o & rows[i][0], rows[i][1] & rows[i][0])
    end
    wb(1'b1, AD, 8'hff);
    wb(1'b1, AL, 8'hff);
    wb(1'b0, AD, 8'h00);
    `CHK(r, DIR_READ_VALUE)
    wb(1'b0, AL, 8'h00);
    `CHK(r, 8'hf8)
    `CHK(port_a_pins, {8'hf8, 8'hf8})
    power_mode <= GPP78_SLEEP;
    wb(1'b1, AL, 8'h00);
    step(2);
    `CHK(port_a_pins, {8'hf8, 8'hf8})
    power_mode <= GPP78_STANDBY;
    step(2);
    `CHK(port_a_pins.oe, 8'h00)
    power_mode <= GPP78_ACTIVE;
    step(2);
    `CHK(port_a_pins, {8'h00, 8'hf8})
    wb(1'b1, AD, 8'h00);
    osel <= 4'h9;
    tco <= 1'b1;
    step(3);
    `CHK(port_a_pins, {8'h40, 8'h40})
    tco <= 1'b0;
    step(2);
    `CHK(port_a_pins.o[6], 1'b0)
    osel <= 4'h0;
    a_ext <= 8'h10;
    step(5);
    `CHK(port_a_pins.oe[6], 1'b0)
    `CHK({tclk, trst}, 2'b01)
    wb(1'b0, AL, 8'h00);
    `CHK(r, 8'h10)
    wb(1'b0, 18'h00100, 8'h00);
    `CHK(r, 8'h00)
    rst <= 1'b1;
    step(2);
    rst <= 1'b0;
    step(2);
    `CHK({port_a_pins, port_b_pins}, 32'h0)
    wb(1'b1, BD, 8'hff);
    wb(1'b0, BL, 8'h00);
    `CHK(r, RST_LATCH)
    stop_test();
  end
endmodule // tb_top
bind gpp78_ports gpp78_chk u_chk (.clock, .rst, .wb_req, .wb_dat_o, .wb_ack_o, .power_mode, .port_a_in,
  .port_a_pins, .port_b_pins, .timer_output_select, .timer_compare_out, .timer_clock_in);
